// >>> logic/urx_pkg.sv
// Purpose: Constants and types for the receive-side serial block
// Assumes: 100 MHz bus clock, Avalon-MM register access
// Notes: Offsets are byte addresses of 32-bit words
package urx_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL1 = 5'h00;
    localparam logic [4:0] OFS_CTRL2 = 5'h04;
    localparam logic [4:0] OFS_STAT1 = 5'h08;
    localparam logic [4:0] OFS_STAT2 = 5'h0c;
    localparam logic [4:0] OFS_DATA  = 5'h10;
    localparam logic [4:0] OFS_BAUD  = 5'h14;
    // Status 1 bit positions, plus the Status 2 direction bit
    localparam int B_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int B_TC   = 6;
    localparam int B_RX_BUFFER_FULL_FLAG = 5;
    localparam int B_IDLE = 4;
    localparam int B_OR   = 3;
    localparam int B_NF   = 2;
    localparam int B_FE   = 1;
    localparam int B_DIR  = 1;
    // Oversampling points
    localparam logic [4:0] RT_FIRST = 5'h01;
    localparam logic [4:0] RT_V1    = 5'h03;
    localparam logic [4:0] RT_V2    = 5'h05;
    localparam logic [4:0] RT_V3    = 5'h07;
    localparam logic [4:0] RT_S1    = 5'h08;
    localparam logic [4:0] RT_S2    = 5'h09;
    localparam logic [4:0] RT_S3    = 5'h0a;
    localparam logic [4:0] RT_LAST  = 5'h10;
    // Idle thresholds in ticks (10 or 11 bit times of 16), last data bit index, reset baud divisor
    localparam logic [7:0] IDLE_8   = 8'ha0;
    localparam logic [7:0] IDLE_9   = 8'hb0;
    localparam logic [3:0] LAST_8   = 4'h7;
    localparam logic [3:0] LAST_9   = 4'h8;
    localparam logic [15:0] BAUD_RST = 16'h0036;

    typedef enum logic [1:0] {
        ST_HUNT  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } urx_state_t;

    // Control 1 fields
    typedef struct packed {
        logic internal_loop_en;
        logic rx_source_sel;
        logic quiet_count_start_sel;
        logic wake_sel;
        logic nine_bit;
    } urx_cfg_t;

    // Control 2 fields
    typedef struct packed {
        logic tc_ie;
        logic tx_buffer_empty_flag_ie;
        logic idle_ie;
        logic rx_ie;
        logic rx_standby_bit;
        logic tx_on;
        logic rx_on;
    } urx_ctl_t;
endpackage

// >>> logic/urx_top.sv
// Purpose: Receive data recovery, wakeup, loop routing, interrupt request
// Assumes: Transmitter lives outside and reports its flags and drive
// Notes: One wait state on every bus access
`timescale 1ns/1ps
module urx_top
    import urx_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV = BAUD_RST
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Serial pins
    input  wire logic        rxd_i,
    input  wire logic        txd_i,
    output logic             txd_o,
    output logic             txd_oe_n,
    // Transmitter side
    input  wire logic        tx_drive,
    input  wire logic        tx_buffer_empty_flag,
    input  wire logic        tx_done_flag,
    output logic             tx_on,
    // Interrupt request
    output logic             irq
);
    urx_cfg_t   cfg;
    urx_ctl_t   ctl;
    urx_state_t state;
    logic        single_pin_direction;
    logic [15:0] baud;
    logic [15:0] div_cnt;
    logic        tick;
    logic        rxd_meta, rxd_s, txd_meta, txd_s;
    logic        line;
    logic [2:0]  hist;
    logic [1:0]  smp;
    logic [4:0]  rt;
    logic [3:0]  bitn;
    logic [8:0]  shift;
    logic [8:0]  rx_data;
    logic        nf_pend, prev_bit;
    logic        rx_buffer_full_flag, idle_flag, overrun_flag;
    logic        noise_flag, stop_bit_fault_flag, idle_armed;
    logic [7:0]  idle_cnt;
    logic        acc, wr, done, stop_bit, stop_fe, stop_nf, msb_hit;
    logic [2:0]  trio;
    logic [7:0]  idle_thr;
    logic        idle_hit, wake_idle;

    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic mixed3(input logic [2:0] v);
        mixed3 = (v != 3'h0) && (v != 3'h7);
    endfunction

    //--------------------------------------------------------------
    // Bus slave
    //--------------------------------------------------------------
    assign acc = (read | write) & waitrequest;
    // Writes land only at the edge that samples waitrequest low
    assign wr  = write & ~waitrequest;

    // One wait state, then accept
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            waitrequest <= 1'b1;
        else
            waitrequest <= ~acc;

    // Read data mux, unmapped reads as zero
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            readdata <= 32'h0;
        else if (read & acc)
        begin
            readdata <= 32'h0;
            case (address)
                OFS_CTRL1: readdata[4:0] <= cfg;
                OFS_CTRL2: readdata[6:0] <= ctl;
                OFS_STAT1: readdata[7:0] <= {tx_buffer_empty_flag,
                    tx_done_flag, rx_buffer_full_flag, idle_flag,
                    overrun_flag, noise_flag, stop_bit_fault_flag, 1'b0};
                OFS_STAT2: readdata[B_DIR] <= single_pin_direction;
                OFS_DATA:  readdata[8:0] <= rx_data;
                OFS_BAUD:  readdata[15:0] <= baud;
                default:   readdata <= 32'h0;
            endcase
        end

    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            cfg <= '0;
            baud <= BAUD_DIV;
            single_pin_direction <= 1'b0;
        end
        else if (wr)
        begin
            if (address == OFS_CTRL1)
                cfg <= writedata[4:0];
            if (address == OFS_BAUD)
                baud <= (writedata[15:0] == 16'h0) ? 16'h1
                                                   : writedata[15:0];
            if (address == OFS_STAT2)
                single_pin_direction <= writedata[B_DIR];
        end

    // Control 2; software setting standby wins over a wake
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            ctl <= '0;
        else if (wr && address == OFS_CTRL2)
            ctl <= writedata[6:0];
        else if (ctl.rx_standby_bit && (wake_idle || msb_hit))
            ctl.rx_standby_bit <= 1'b0;
        else
            ctl <= ctl;

    //--------------------------------------------------------------
    // Pins and receiver source
    //--------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            rxd_meta <= 1'b1;
            rxd_s <= 1'b1;
            txd_meta <= 1'b1;
            txd_s <= 1'b1;
        end
        else
        begin
            rxd_meta <= rxd_i;
            rxd_s <= rxd_meta;
            txd_meta <= txd_i;
            txd_s <= txd_meta;
        end

    // Source mux and pin drive
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            line <= 1'b1;
            txd_o <= 1'b1;
            txd_oe_n <= 1'b0;
            tx_on <= 1'b0;
        end
        else
        begin
            if (!cfg.internal_loop_en)
                line <= rxd_s;
            else if (cfg.rx_source_sel)
                line <= txd_s;
            else
                line <= tx_drive;
            txd_o <= tx_drive;
            txd_oe_n <= cfg.internal_loop_en & cfg.rx_source_sel
                        & ~single_pin_direction;
            tx_on <= ctl.tx_on;
        end

    //--------------------------------------------------------------
    // Oversampling tick
    //--------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            div_cnt <= 16'h0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (div_cnt >= baud - 16'h1);
            div_cnt <= (div_cnt >= baud - 16'h1) ? 16'h0
                                                 : div_cnt + 16'h1;
        end

    //--------------------------------------------------------------
    // Data recovery
    //--------------------------------------------------------------
    assign trio     = {smp, line};
    assign stop_bit = maj3(trio);
    assign stop_fe  = ~stop_bit;
    assign stop_nf  = mixed3(trio);
    assign done     = tick && state == ST_STOP && rt == RT_S3;
    assign msb_hit  = tick && state == ST_DATA && rt == RT_S3 &&
                      cfg.wake_sel && maj3(trio) &&
                      bitn == (cfg.nine_bit ? LAST_9 : LAST_8);

    // Frame state machine
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            state <= ST_HUNT;
            rt <= RT_FIRST;
            bitn <= 4'h0;
            hist <= 3'h7;
            smp <= 2'h0;
            shift <= 9'h0;
            nf_pend <= 1'b0;
            prev_bit <= 1'b1;
        end
        else if (!ctl.rx_on)
        begin
            state <= ST_HUNT;
            hist <= 3'h7;
        end
        else if (tick)
        begin
            hist <= {hist[1:0], line};
            rt <= rt + 5'h1;
            if (rt == RT_V1 || rt == RT_V2 || rt == RT_S1 || rt == RT_S2)
                smp <= {smp[0], line};
            case (state)
                ST_HUNT:
                    if (hist == 3'h7 && !line)
                    begin
                        state <= ST_START;
                        rt <= RT_FIRST + 5'h1;
                        nf_pend <= 1'b0;
                        shift <= 9'h0;
                    end
                ST_START:
                begin
                    if (rt == RT_V3)
                    begin
                        if (maj3(trio))
                            state <= ST_HUNT;
                        else if (trio != 3'h0)
                            nf_pend <= 1'b1;
                    end
                    // Value ignored, any high marks noise
                    if (rt == RT_S3 && trio != 3'h0)
                        nf_pend <= 1'b1;
                    if (rt == RT_LAST)
                    begin
                        state <= ST_DATA;
                        rt <= RT_FIRST;
                        bitn <= 4'h0;
                        prev_bit <= 1'b0;
                    end
                end
                ST_DATA:
                begin
                    if (rt == RT_S3)
                    begin
                        shift[bitn] <= maj3(trio);
                        prev_bit <= maj3(trio);
                        if (mixed3(trio))
                            nf_pend <= 1'b1;
                    end
                    // Realign on a clean high-to-low edge
                    if (prev_bit && hist == 3'h7 && !line &&
                        (rt > RT_S3 || rt < RT_S1))
                    begin
                        rt <= RT_FIRST + 5'h1;
                        if (rt > RT_S3)
                            bitn <= bitn + 4'h1;
                        prev_bit <= 1'b0;
                    end
                    else if (rt == RT_LAST)
                    begin
                        rt <= RT_FIRST;
                        bitn <= bitn + 4'h1;
                    end
                    if ((rt == RT_LAST || rt > RT_S3) && bitn ==
                        (cfg.nine_bit ? LAST_9 : LAST_8) &&
                        (rt == RT_LAST || (prev_bit && hist == 3'h7
                         && !line)))
                        state <= ST_STOP;
                end
                ST_STOP:
                    if (rt == RT_S3)
                    begin
                        state <= ST_HUNT;
                        hist <= {hist[1:0], line};
                    end
                default:
                    state <= ST_HUNT;
            endcase
        end

    //--------------------------------------------------------------
    // Receive flags and data
    //--------------------------------------------------------------
    // Frame end; hardware set wins over software clear
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            rx_data <= 9'h0;
            rx_buffer_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            stop_bit_fault_flag <= 1'b0;
        end
        else
        begin
            if (wr && address == OFS_STAT1)
            begin
                rx_buffer_full_flag <= rx_buffer_full_flag
                                       & ~writedata[B_RX_BUFFER_FULL_FLAG];
                overrun_flag <= overrun_flag & ~writedata[B_OR];
                noise_flag <= noise_flag & ~writedata[B_NF];
                stop_bit_fault_flag <= stop_bit_fault_flag
                                       & ~writedata[B_FE];
            end
            if (done)
            begin
                if (rx_buffer_full_flag && !ctl.rx_standby_bit)
                    overrun_flag <= 1'b1;
                else
                begin
                    // Standby loads data without full flag
                    rx_data <= cfg.nine_bit ? shift
                                            : {1'b0, shift[7:0]};
                    rx_buffer_full_flag <= !ctl.rx_standby_bit;
                    if (stop_fe)
                        stop_bit_fault_flag <= 1'b1;
                    if (stop_nf || nf_pend)
                        noise_flag <= 1'b1;
                end
            end
        end

    //--------------------------------------------------------------
    // Idle detection and wakeup
    //--------------------------------------------------------------
    assign idle_thr  = cfg.nine_bit ? IDLE_9 : IDLE_8;
    assign idle_hit  = tick && line && idle_cnt == idle_thr - 8'h1;
    assign wake_idle = !cfg.wake_sel && idle_cnt >= idle_thr;

    // Count ticks of high line
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            idle_cnt <= 8'h0;
        else if (!line || (cfg.quiet_count_start_sel && state != ST_HUNT))
            idle_cnt <= 8'h0;
        else if (tick && idle_cnt != 8'hff)
            idle_cnt <= idle_cnt + 8'h1;

    // Idle flag armed by a received frame
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            idle_flag <= 1'b0;
            idle_armed <= 1'b0;
        end
        else
        begin
            if (wr && address == OFS_STAT1 && writedata[B_IDLE])
                idle_flag <= 1'b0;
            if (done && !ctl.rx_standby_bit)
                idle_armed <= 1'b1;
            else if (idle_hit && idle_armed && !ctl.rx_standby_bit)
            begin
                idle_flag <= 1'b1;
                idle_armed <= 1'b0;
            end
        end

    //--------------------------------------------------------------
    // Interrupt request
    //--------------------------------------------------------------
    // Level request, also usable as a wait-mode wake
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= (tx_buffer_empty_flag & ctl.tx_buffer_empty_flag_ie) |
                   (tx_done_flag & ctl.tc_ie) |
                   (!ctl.rx_standby_bit &
                    ((rx_buffer_full_flag & ctl.rx_ie) |
                     (overrun_flag & ctl.rx_ie) |
                     (idle_flag & ctl.idle_ie)));

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_fe_with_rx_buffer_full_flag;
        done && stop_fe && !ctl.rx_standby_bit && !rx_buffer_full_flag
        |=> stop_bit_fault_flag && rx_buffer_full_flag;
    endproperty
    a_fe_with_rx_buffer_full_flag: assert property (p_fe_with_rx_buffer_full_flag)
        else $error("Fault flag not set with full flag");

    property p_noise_stop;
        done && stop_nf && !rx_buffer_full_flag |=> noise_flag;
    endproperty
    a_noise_stop: assert property (p_noise_stop)
        else $error("Stop noise not flagged");

    property p_standby_no_rx_buffer_full_flag;
        done && ctl.rx_standby_bit && !rx_buffer_full_flag
        |=> !rx_buffer_full_flag;
    endproperty
    a_standby_no_rx_buffer_full_flag: assert property (p_standby_no_rx_buffer_full_flag)
        else $error("Full flag set in standby");

    property p_standby_irq;
        ctl.rx_standby_bit && !ctl.tx_buffer_empty_flag_ie && !ctl.tc_ie |=> !irq;
    endproperty
    a_standby_irq: assert property (p_standby_irq)
        else $error("Receive request during standby");

    property p_addr_wake;
        msb_hit && ctl.rx_standby_bit && !wr |=> !ctl.rx_standby_bit;
    endproperty
    a_addr_wake: assert property (p_addr_wake)
        else $error("Address frame did not wake");

    property p_irq_or;
        ##1 irq == $past((tx_buffer_empty_flag & ctl.tx_buffer_empty_flag_ie) |
            (tx_done_flag & ctl.tc_ie) | (!ctl.rx_standby_bit &
            ((rx_buffer_full_flag | overrun_flag) & ctl.rx_ie |
             idle_flag & ctl.idle_ie)));
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("Request does not follow sources");

    property p_loop_src;
        (cfg.internal_loop_en && !cfg.rx_source_sel) [*2] |=>
        line == $past(tx_drive);
    endproperty
    a_loop_src: assert property (p_loop_src)
        else $error("Loop source wrong");

    property p_dir;
        cfg.internal_loop_en && cfg.rx_source_sel |=>
        txd_oe_n == !$past(single_pin_direction);
    endproperty
    a_dir: assert property (p_dir)
        else $error("Pin direction wrong");

    property p_wait;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("Wait state count wrong");
endmodule

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the receive-side serial block
// Assumes: Baud divisor 1, so one bit lasts 16 bus clocks
// Notes: Line routing follows the loop mode under test
`timescale 1ns/1ps
module testbench;
    import urx_pkg::*;
    // ------------------------------------------------------------
    // Signals, clock, routing
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        sys_rst, read, write, rxd_i, txd_i, tx_drive, line;
    logic        tx_buffer_empty_flag, tx_done_flag;
    logic        waitrequest, txd_o, txd_oe_n, tx_on, irq;
    logic [4:0]  address;
    logic [1:0]  route;
    logic [31:0] writedata, readdata, d;
    int          fails = 0, num_checks = 0, cyc = 0;

    always #5 clk = ~clk;
    // Route 0 normal pin, 1 internal loop, 2 single wire
    assign rxd_i    = (route == 2'd0) ? line : 1'b0;
    assign tx_drive = (route == 2'd1) ? line : 1'b1;
    assign txd_i    = (route == 2'd2) ? line : 1'b1;

    urx_top #(.BAUD_DIV(16'h0036)) urx_top_inst (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rxd_i(rxd_i), .txd_i(txd_i),
        .txd_o(txd_o), .txd_oe_n(txd_oe_n), .tx_drive(tx_drive),
        .tx_buffer_empty_flag(tx_buffer_empty_flag),
        .tx_done_flag(tx_done_flag), .tx_on(tx_on), .irq(irq));
    urx_tx_model urx_tx_model_inst (.clk(clk), .line(line));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Avalon access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        address <= a; write <= wr; read <= ~wr; writedata <= wd;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        d = readdata;
        read <= 1'b0; write <= 1'b0;
    endtask

    task automatic frame(input logic [8:0] v, input logic stop);
        urx_tx_model_inst.send(v, 8, stop);
    endtask

    task automatic noisy(input logic [8:0] v, input int s_lo,
                         input int s_hi, input int p_lo, input int p_hi);
        urx_tx_model_inst.send_noisy(v, 8, s_lo, s_hi, p_lo, p_hi);
    endtask

    task automatic irq_is(input logic exp);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        bus(0, OFS_BAUD, 0);  chk(d, 32'h36);
        bus(0, OFS_CTRL2, 0); chk(d, 32'h0);
        bus(0, 5'h18, 0);     chk(d, 32'h0);
        bus(1, OFS_BAUD, 32'h1);
        bus(1, OFS_CTRL2, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, tx_on}, 32'h1);
    endtask

    task automatic t_frame;
        frame(9'h0a5, 1'b1);
        bus(0, OFS_STAT1, 0); chk(d, 32'h20);
        bus(0, OFS_DATA, 0);  chk(d, 32'ha5);
        repeat (180) @(posedge clk);
        bus(0, OFS_STAT1, 0); chk(d, 32'h30);
        bus(1, OFS_STAT1, 32'h3e);
        frame(9'h000, 1'b0);
        bus(0, OFS_STAT1, 0); chk(d, 32'h22);
        bus(0, OFS_DATA, 0);  chk(d, 32'h0);
        bus(1, OFS_STAT1, 32'h3e);
    endtask

    // Glitched stop and start bits, then idle-line wakeup
    task automatic t_noise;
        noisy(9'h05a, 1, 0, 8, 8);
        bus(0, OFS_STAT1, 0); chk(d & 32'h2e, 32'h24);
        bus(1, OFS_STAT1, 32'h3e);
        noisy(9'h05a, 7, 9, 1, 0);
        bus(0, OFS_STAT1, 0); chk(d & 32'h2e, 32'h24);
        bus(0, OFS_DATA, 0);  chk(d, 32'h5a);
        bus(1, OFS_STAT1, 32'h3e);
        bus(1, OFS_CTRL2, 32'h7);
        bus(0, OFS_CTRL2, 0); chk(d, 32'h7);
        repeat (180) @(posedge clk);
        bus(0, OFS_CTRL2, 0); chk(d, 32'h3);
        bus(0, OFS_STAT1, 0); chk(d & 32'h30, 32'h0);
    endtask

    task automatic t_wake;
        bus(1, OFS_CTRL1, 32'h2);
        bus(1, OFS_CTRL2, 32'h7);
        frame(9'h005, 1'b1);
        bus(0, OFS_STAT1, 0); chk(d & 32'h20, 32'h0);
        bus(0, OFS_DATA, 0);  chk(d, 32'h05);
        frame(9'h085, 1'b1);
        bus(0, OFS_CTRL2, 0); chk(d, 32'h3);
        bus(0, OFS_STAT1, 0); chk(d & 32'h20, 32'h20);
    endtask

    task automatic t_irq;
        bus(1, OFS_CTRL2, 32'h0b); irq_is(1'b1);
        bus(1, OFS_CTRL2, 32'h0f); irq_is(1'b0);
        bus(1, OFS_CTRL2, 32'h0b);
        bus(1, OFS_STAT1, 32'h3e); irq_is(1'b0);
        tx_buffer_empty_flag <= 1'b1; irq_is(1'b0);
        bus(1, OFS_CTRL2, 32'h2b); irq_is(1'b1);
        tx_buffer_empty_flag <= 1'b0;
        tx_done_flag <= 1'b1;      irq_is(1'b0);
        bus(1, OFS_CTRL2, 32'h4b); irq_is(1'b1);
        tx_done_flag <= 1'b0;      irq_is(1'b0);
    endtask

    task automatic t_loop;
        bus(1, OFS_CTRL2, 32'h3);
        bus(1, OFS_CTRL1, 32'h10);
        route <= 2'd1;
        frame(9'h03c, 1'b1);
        bus(0, OFS_DATA, 0);  chk(d, 32'h3c);
        bus(0, OFS_STAT1, 0); chk(d & 32'h22, 32'h20);
        bus(1, OFS_STAT1, 32'h3e);
        bus(1, OFS_CTRL1, 32'h18);
        route <= 2'd2;
        bus(1, OFS_STAT2, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, txd_oe_n}, 32'h1);
        frame(9'h0c3, 1'b1);
        bus(0, OFS_DATA, 0);  chk(d, 32'hc3);
        bus(1, OFS_STAT2, 32'h2);
        repeat (3) @(posedge clk);
        chk({31'h0, txd_oe_n}, 32'h0);
        chk({31'h0, txd_o}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict;
        end
    end

    initial
    begin
        sys_rst = 1'b1; address = 5'h0; read = 1'b0; write = 1'b0;
        writedata = 32'h0; route = 2'd0;
        tx_buffer_empty_flag = 1'b0; tx_done_flag = 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_frame;
        t_noise;
        t_wake;
        t_irq;
        t_loop;
        print_verdict;
    end
endmodule

// >>> testbench/urx_tx_model.sv
// Purpose: Remote serial transmitter driving the receive line
// Assumes: Bit time of BIT_CLKS bus clocks, line idles high
// Notes: Frames are start bit, data lsb first, stop bit, idle bit
`timescale 1ns/1ps
module urx_tx_model #(
    parameter int BIT_CLKS = 16
)(
    // Clock and serial line
    input  wire logic clk,
    output logic      line
);
    // ------------------------------------------------------------
    // Frame generator
    // ------------------------------------------------------------
    initial line = 1'b1;

    // One bit held for a full bit time, changed after an edge
    task automatic bit_out(input logic v);
        @(posedge clk);
        line <= v;
        repeat (BIT_CLKS - 1) @(posedge clk);
    endtask

    // A zero stop bit with zero data makes a break
    task automatic send(input logic [8:0] v, input int nbits,
                        input logic stop);
        int i;
        bit_out(1'b0);
        for (i = 0; i < nbits; i++)
            bit_out(v[i]);
        bit_out(stop);
        bit_out(1'b1);
    endtask

    // One bit whose level is flipped from tick lo to tick hi
    task automatic bit_flip(input logic v, input int lo, input int hi);
        int k;
        for (k = 0; k < BIT_CLKS; k++)
        begin
            @(posedge clk);
            line <= (k >= lo && k <= hi) ? ~v : v;
        end
    endtask

    // Frame with glitches inside the start and stop bits
    task automatic send_noisy(input logic [8:0] v, input int nbits,
                              input int s_lo, input int s_hi,
                              input int p_lo, input int p_hi);
        int i;
        bit_flip(1'b0, s_lo, s_hi);
        for (i = 0; i < nbits; i++)
            bit_out(v[i]);
        bit_flip(1'b1, p_lo, p_hi);
        bit_out(1'b1);
    endtask
endmodule
